// [core/stcmd_handler.v]
/*
 * Self-test command handler: decodes disable and enable self-test
 * commands, keeps the lockout state, drives the self-test plate and
 * builds the short and long status responses.
 * Assumes a frame decoder on ref_clk that has already checked CRC and
 * framing and presents each good command as a one-cycle strobe.
 * Software reaches configuration over Avalon-MM with waitrequest.
 */
`timescale 1ns/1ps
`include "stcmd_map.vh"

module stcmd_handler (
	// clock and reset
	input  wire        ref_clk,
	input  wire        sys_rst,
	// avalon-mm slave
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	// decoded command from frame logic
	input  wire        cmdStrobe,
	input  wire [3:0]  cmdCode,
	input  wire [3:0]  cmdAddr,
	input  wire [7:0]  cmdData,
	input  wire        cmdLong,
	input  wire        cmdEnhanced,
	input  wire        cmdFromDownstream,
	// reset and clear events, in-domain pulses
	input  wire        clearCmdSeen,
	input  wire        frameTimeout,
	// analogue monitors, asynchronous levels
	input  wire        holdCapUnderVolt,
	input  wire        holdCapLow,
	// device state from other logic
	input  wire        internalError,
	input  wire        busSwitchClose,
	input  wire        otpProgEnabled,
	// self-test actuator
	output reg         selfTestDrive_q,
	output reg         lockout_q,
	// response to frame logic
	output reg         respValid_q,
	output reg         respLong_q,
	output reg  [15:0] respData_q
);

	// ****************************************
	// functions
	// ****************************************

	// accepted formats: enhanced only once selected
	function fmtAllowed;
		input       enh;
		input [3:0] sel;
		begin
			fmtAllowed = !enh || (sel == `STC_FMT_ENH);
		end
	endfunction

	// status byte shared by short and long answers
	function [7:0] statusByte;
		input       prog;
		input       capLow;
		input       stOn;
		input       busSw;
		input [1:0] tag;
		input       err;
		begin
			statusByte = {prog, capLow, stOn, busSw, tag, err, 1'b0};
		end
	endfunction

	// ****************************************
	// declarations
	// ****************************************

	reg  [3:0] devAddr_q;
	reg  [1:0] userTagBits_q;
	reg  [3:0] formatSel_q;
	reg        disPending_q;
	reg        uvSync1_q;
	reg        uvSync2_q;
	reg        lowSync1_q;
	reg        lowSync2_q;
	reg        respNext;

	wire       busReq;
	wire       busDone;
	wire       isDis;
	wire       isEn;
	wire       isIgnored;
	wire       fmtOk;
	wire       addrHit;
	wire       addrGlobal;
	wire       disAccept;
	wire       enAccept;
	wire       otherAccept;
	wire       lockRelease;
	wire       lockSet;
	wire       driveNext;
	wire [7:0] statNow;
	wire [7:0] dataUnused;

	// ****************************************
	// synchronisers for analogue monitors
	// ****************************************

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			uvSync1_q  <= 1'b0;
			uvSync2_q  <= 1'b0;
			lowSync1_q <= 1'b0;
			lowSync2_q <= 1'b0;
		end else begin
			uvSync1_q  <= holdCapUnderVolt;
			uvSync2_q  <= uvSync1_q;
			lowSync1_q <= holdCapLow;
			lowSync2_q <= lowSync1_q;
		end
	end

	// ****************************************
	// command decode
	// ****************************************

	// data bits only feed the crc upstream
	assign dataUnused = cmdData;

	assign isDis = (cmdCode == `STC_CMD_DIS);
	assign isEn  = (cmdCode == `STC_CMD_EN);

	// unimplemented codes and the downstream side never act
	assign isIgnored = cmdFromDownstream
		|| (cmdCode == `STC_CMD_RSV14)
		|| (cmdCode == `STC_CMD_RSV15);

	assign fmtOk      = fmtAllowed(cmdEnhanced, formatSel_q);
	assign addrGlobal = (cmdAddr == `STC_ADDR_GLOBAL);
	assign addrHit    = (cmdAddr == devAddr_q) && !addrGlobal;

	// global disable acts, global enable does not
	assign disAccept = cmdStrobe && !isIgnored && fmtOk && isDis
		&& (addrHit || addrGlobal);
	assign enAccept  = cmdStrobe && !isIgnored && fmtOk && isEn
		&& addrHit;

	// any other command to us except codes 1110 and 1111 breaks a disable pair
	assign otherAccept = cmdStrobe && !isIgnored && fmtOk && addrHit
		&& !isDis && !isEn;

	// ****************************************
	// lockout and self-test drive
	// ****************************************

	assign lockRelease = uvSync2_q || clearCmdSeen || frameTimeout;
	assign lockSet     = disAccept && disPending_q;

	assign driveNext = disAccept ? 1'b0 :
		(enAccept && !lockout_q) ? 1'b1 :
		frameTimeout ? 1'b0 :
		selfTestDrive_q;

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			selfTestDrive_q <= 1'b0;
			lockout_q       <= 1'b0;
			disPending_q    <= 1'b0;
		end else begin
			selfTestDrive_q <= driveNext;
			// a second disable in the release cycle still locks
			if (lockSet)
				lockout_q <= 1'b1;
			else if (lockRelease)
				lockout_q <= 1'b0;
			if (disAccept)
				disPending_q <= !disPending_q;
			else if (enAccept || otherAccept || lockRelease)
				disPending_q <= 1'b0;
		end
	end

	// ****************************************
	// response build
	// ****************************************

	assign statNow = statusByte(
		otpProgEnabled,
		lowSync2_q,
		driveNext,
		busSwitchClose,
		userTagBits_q,
		internalError);

	always @* begin
		respNext = (disAccept && !addrGlobal) || enAccept;
	end

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			respValid_q <= 1'b0;
			respLong_q  <= 1'b0;
			respData_q  <= 16'h0000;
		end else begin
			respValid_q <= respNext;
			if (respNext) begin
				respLong_q <= cmdLong;
				if (cmdLong)
					respData_q <= {devAddr_q, 4'h0, statNow};
				else
					respData_q <= {1'b0, 7'h00, statNow};
			end
		end
	end

	// ****************************************
	// avalon-mm slave
	// ****************************************

	// one wait state: data is loaded on the same edge that drops waitrequest
	assign busReq  = avs_read || avs_write;
	assign busDone = busReq && !avs_waitrequest;

	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			if (busReq && avs_waitrequest)
				avs_waitrequest <= 1'b0;
			else
				avs_waitrequest <= 1'b1;
			if (avs_read && avs_waitrequest) begin
				case (avs_address)
					`STC_REG_CFG:
						avs_readdata <= {26'h000_0000, userTagBits_q, devAddr_q};
					`STC_REG_FMT:
						avs_readdata <= {28'h000_0000, formatSel_q};
					`STC_REG_STAT:
						avs_readdata <= {28'h000_0000, lowSync2_q, disPending_q,
							lockout_q, selfTestDrive_q};
					`STC_REG_RESP:
						avs_readdata <= {14'h0000, respValid_q, respLong_q,
							respData_q};
					default:
						avs_readdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// writes land on the edge that completes the transfer
	always @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			devAddr_q     <= `STC_CFG_RST;
			userTagBits_q <= 2'b00;
			formatSel_q   <= `STC_FMT_RST;
		end else if (busDone && avs_write) begin
			case (avs_address)
				`STC_REG_CFG: begin
					devAddr_q     <= avs_writedata[`STC_CFG_ADDR_LSB +: 4];
					userTagBits_q <= avs_writedata[`STC_CFG_TAG_LSB +: 2];
				end
				`STC_REG_FMT: begin
					// only the two defined selections are taken
					if (avs_writedata[3:0] == `STC_FMT_ENH
						|| avs_writedata[3:0] == `STC_FMT_STD)
						formatSel_q <= avs_writedata[3:0];
				end
				default: begin
					formatSel_q <= formatSel_q;
				end
			endcase
		end
	end

endmodule

// [core/stcmd_map.vh]
/*
 * Constants of the self-test command handler: command codes, field
 * positions, register offsets and reset values.
 * Assumes inclusion by stcmd_handler.v and by the checker and bench; holds definitions only.
 */
// Summary of operation
// - command field 1100 decodes as disable self-test
// - command field 1101 decodes as enable self-test
// - self-test command with foreign address ignored, global disable excepted
// - disable to global address 0000 acts but sends no response
// - enable to global address 0000 is ignored entirely
// - eight command data bits feed CRC only, no other meaning
// - both commands accepted in standard and enhanced, long and short formats
// - short response 15 bits: zeros, prog, caplow, selftest, switch, tag, error, 0
// - long response 16 bits: address, four zeros, same status byte
// - error flag is 1 on internal device error, else 0
// - self-test bit is 1 while self-test circuitry active
// - bus-switch bit is 1 when switch is to be closed
// - programming-enable bit is 1 when OTP programming is enabled
// - capacitor-low bit set while hold-capacitor voltage under threshold
// - tag bits copied from attribute field of config register one
// - two successive disable commands activate self-test lockout
// - lockout held until cap undervoltage, Clear, regulator or timeout reset
// - under lockout enable leaves self-test off and reports bit cleared
// - accepted enable without lockout drives self-test until a disable; the code also drops it on frame timeout
// - accepted disable removes self-test drive
// - command field 1110 ignored in every format
// - command field 1111 and anything from downstream pin ignored
// - enhanced formats valid only when format selection holds 1111
`ifndef STCMD_MAP_VH
`define STCMD_MAP_VH

// command codes, global address and format selections
`define STC_CMD_DIS       4'b1100
`define STC_CMD_EN        4'b1101
`define STC_CMD_RSV14     4'b1110
`define STC_CMD_RSV15     4'b1111
`define STC_ADDR_GLOBAL   4'h0
`define STC_FMT_ENH       4'hf
`define STC_FMT_STD       4'h0

// register byte offsets
`define STC_REG_CFG       4'h0
`define STC_REG_FMT       4'h4
`define STC_REG_STAT      4'h8
`define STC_REG_RESP      4'hc

// config register fields and reset values
`define STC_CFG_ADDR_LSB  0
`define STC_CFG_TAG_LSB   4
`define STC_CFG_RST       4'h0
`define STC_FMT_RST       4'h0

`endif

// [testbench/stcmd_checker.sv]
/* port assertions for the self-test command handler.
   assumes stcmd_map.vh on the include path and one clock domain. */
`timescale 1ns/1ps
`include "stcmd_map.vh"
module stcmd_checker (
	// clock and reset
	input wire        ref_clk,
	input wire        sys_rst,
	// command side
	input wire        cmdStrobe,
	input wire [3:0]  cmdCode,
	input wire [3:0]  cmdAddr,
	input wire        cmdLong,
	input wire        cmdEnhanced,
	input wire        cmdFromDownstream,
	input wire        clearCmdSeen,
	input wire        frameTimeout,
	input wire        internalError,
	input wire        busSwitchClose,
	input wire        otpProgEnabled,
	// outputs
	input wire        selfTestDrive_q,
	input wire        lockout_q,
	input wire        respValid_q,
	input wire        respLong_q,
	input wire [15:0] respData_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire isEn = cmdStrobe && cmdCode == `STC_CMD_EN;
	wire isDis = cmdStrobe && cmdCode == `STC_CMD_DIS;
	// clear and timeout events are excluded: they may win against the command
	wire noRel = !clearCmdSeen && !frameTimeout;
	property p_rsv; cmdStrobe && cmdCode[3:1] == 3'b111 |=> !respValid_q; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved code answered");
	property p_down;
		cmdStrobe && cmdFromDownstream && noRel |=> !respValid_q && $stable(selfTestDrive_q);
	endproperty
	a_down: assert property (p_down) else $error("downstream command acted on");
	property p_gen;
		isEn && cmdAddr == `STC_ADDR_GLOBAL && noRel |=> !respValid_q && $stable(selfTestDrive_q);
	endproperty
	a_gen: assert property (p_gen) else $error("global enable acted on");
	property p_gdis;
		isDis && cmdAddr == `STC_ADDR_GLOBAL && !cmdFromDownstream && !cmdEnhanced
			|=> !respValid_q && !selfTestDrive_q;
	endproperty
	a_gdis: assert property (p_gdis) else $error("global disable wrong");
	property p_lock; lockout_q && isEn && noRel |=> !selfTestDrive_q; endproperty
	a_lock: assert property (p_lock) else $error("enable passed lockout");
	property p_st; respValid_q |-> respData_q[5] == selfTestDrive_q; endproperty
	a_st: assert property (p_st) else $error("self-test bit wrong");
	property p_fmt;
		respValid_q |-> respData_q[11:8] == 4'h0 && !respData_q[0]
			&& (respLong_q || respData_q[15:12] == 4'h0);
	endproperty
	a_fmt: assert property (p_fmt) else $error("response zero bits wrong");
	property p_flg;
		respValid_q |-> respData_q[1] == $past(internalError)
			&& respData_q[4] == $past(busSwitchClose)
			&& respData_q[7] == $past(otpProgEnabled) && respLong_q == $past(cmdLong);
	endproperty
	a_flg: assert property (p_flg) else $error("response flags wrong");
	property p_set; $rose(lockout_q) |-> $past(isDis); endproperty
	a_set: assert property (p_set) else $error("lockout without disable");
	property p_on; $rose(selfTestDrive_q) |-> $past(isEn && !lockout_q); endproperty
	a_on: assert property (p_on) else $error("drive without enable");
	c_lock: cover property ($rose(lockout_q));
	c_long: cover property (respValid_q && respLong_q);
	c_on: cover property ($rose(selfTestDrive_q));
endmodule
bind stcmd_handler stcmd_checker chk (.*);

// [testbench/stcmd_master.sv]
/* bus master controller model: hands decoded commands to the handler.
   assumes the tb calls send; one gap cycle between strobes. */
`timescale 1ns/1ps
module stcmd_master (
	// clock
	input wire       ref_clk,
	// decoded command
	output reg       cmdStrobe,
	output reg [3:0] cmdCode,
	output reg [3:0] cmdAddr,
	output reg [7:0] cmdData,
	output reg       cmdLong,
	output reg       cmdEnhanced,
	output reg       cmdFromDownstream
);
	initial {cmdStrobe, cmdCode, cmdAddr, cmdData, cmdLong, cmdEnhanced, cmdFromDownstream} = 0;
	task send(input [3:0] c, input [3:0] a, input l, input e, input d);
		@(posedge ref_clk);
		cmdStrobe <= 1'b1;
		cmdCode <= c;
		cmdAddr <= a;
		cmdData <= ~cmdData;
		{cmdLong, cmdEnhanced, cmdFromDownstream} <= {l, e, d};
		@(posedge ref_clk);
		cmdStrobe <= 1'b0;
		// released code and address fields never keep their last value
		{cmdCode, cmdAddr} <= ~{c, a};
	endtask
endmodule

// [testbench/tb.sv]
/* self-checking bench: register setup, table of commands, then register, event and reset cases.
   assumes stcmd_map.vh on the include path. */
`timescale 1ns/1ps
`include "stcmd_map.vh"
module tb;
	typedef struct packed {logic [3:0] c; logic [3:0] a; logic [3:0] f;} stcmd_row_t;
	logic clk = 0, rst = 1, aRd = 0, aWr = 0, err = 1, bs = 0, otp = 1, capLow = 0;
	logic [3:0] aAddr = 0;
	logic [31:0] aWd = 0, x;
	logic [2:0] evt = 0;
	wire [31:0] aRdata;
	wire [15:0] rd;
	wire [3:0] cc, ca;
	wire [7:0] cdat;
	wire aWait, stb, cl, ce, cdn, drv, lck, rv, rl;
	int failures = 0, cmpCount = 0;
	// flags {long, valid, drive, lockout}; address 5 is programmed first
	stcmd_row_t rows[12] = '{'{4'hd, 4'h5, 4'b1110}, '{4'hd, 4'h0, 4'b0010},
		'{4'he, 4'h5, 4'b0010}, '{4'hf, 4'h5, 4'b0010}, '{4'hd, 4'h3, 4'b0010},
		'{4'hc, 4'h5, 4'b0100}, '{4'hd, 4'h5, 4'b0110}, '{4'hc, 4'h5, 4'b1100},
		'{4'hd, 4'h5, 4'b0110}, '{4'hc, 4'h0, 4'b0000}, '{4'hc, 4'h5, 4'b0101},
		'{4'hd, 4'h5, 4'b1101}};
	stcmd_handler uut (.ref_clk(clk), .sys_rst(rst), .avs_address(aAddr), .avs_read(aRd),
		.avs_write(aWr), .avs_writedata(aWd), .avs_readdata(aRdata),
		.avs_waitrequest(aWait), .cmdStrobe(stb), .cmdCode(cc), .cmdAddr(ca),
		.cmdData(cdat), .cmdLong(cl), .cmdEnhanced(ce), .cmdFromDownstream(cdn),
		.clearCmdSeen(evt[0]), .frameTimeout(evt[1]), .holdCapUnderVolt(evt[2]),
		.holdCapLow(capLow), .internalError(err), .busSwitchClose(bs),
		.otpProgEnabled(otp), .selfTestDrive_q(drv), .lockout_q(lck),
		.respValid_q(rv), .respLong_q(rl), .respData_q(rd));
	stcmd_master m (.ref_clk(clk), .cmdStrobe(stb), .cmdCode(cc), .cmdAddr(ca),
		.cmdData(cdat), .cmdLong(cl), .cmdEnhanced(ce), .cmdFromDownstream(cdn));
	initial forever #12.5 clk = ~clk;
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmpCount++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		@(posedge clk);
		{aWr, aRd, aAddr, aWd} <= {w, !w, a, d};
		@(posedge clk);
		while (aWait) @(posedge clk);
		x = aRdata;
		{aWr, aRd} <= 2'b00;
	endtask
	task pulse(input [2:0] v);
		@(posedge clk);
		evt <= v;
		// the undervoltage level passes a two-stage synchroniser
		repeat (v[2] ? 4 : 1) @(posedge clk);
		evt <= 3'b000;
		#1;
	endtask
	task cmd(input [3:0] c, input l, input e, input d, input [3:0] f);
		m.send(c, 4'h5, l, e, d);
		#1;
		chk({rv, drv, lck}, f[2:0]);
		if (f[2]) chk(rd, l ? {8'h50, otp, capLow, f[1], bs, 2'b10, err, 1'b0}
			: {8'h00, otp, capLow, f[1], bs, 2'b10, err, 1'b0});
	endtask
	task summarize;
		$display("comparisons %0d failures %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		summarize;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		bus(0, 4'h0, 0);
		chk(x, 0);
		bus(1, 4'h0, 32'h0000_0025);
		bus(1, 4'h4, 32'h0000_0003);
		bus(0, 4'h4, 0);
		chk(x, 0);
		bus(0, 4'h2, 0);
		chk(x, 0);
		foreach (rows[i]) begin
			m.send(rows[i].c, rows[i].a, rows[i].f[3], 1'b0, 1'b0);
			#1;
			chk({rv, drv, lck}, rows[i].f[2:0]);
		end
		bus(0, 4'h8, 0);
		chk(x, 32'h0000_0002);
		bus(0, 4'hc, 0);
		chk(x, 32'h0001_508a);
		pulse(3'b001);
		chk(lck, 0);
		cmd(`STC_CMD_EN, 0, 1, 0, 4'b0000);
		bus(1, 4'h4, 32'h0000_000f);
		cmd(`STC_CMD_EN, 0, 1, 0, 4'b0110);
		cmd(`STC_CMD_DIS, 0, 0, 1, 4'b0010);
		pulse(3'b010);
		chk(drv, 0);
		cmd(`STC_CMD_DIS, 0, 1, 0, 4'b0100);
		cmd(`STC_CMD_DIS, 1, 1, 0, 4'b0101);
		pulse(3'b100);
		chk(lck, 0);
		@(posedge clk);
		{err, bs, otp, capLow} <= 4'b0101;
		repeat (3) @(posedge clk);
		cmd(`STC_CMD_EN, 1, 0, 0, 4'b0110);
		cmd(`STC_CMD_DIS, 0, 0, 0, 4'b0100);
		cmd(`STC_CMD_DIS, 0, 0, 0, 4'b0101);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		#1;
		chk({rv, drv, lck}, 0);
		summarize;
	end
endmodule
